// file: rtl/pxf_fabric.sv
// Purpose: Peripheral crossbar fabric with protected crossbar select fields and an unprotected timer-select register
// Assumes: Plain register port on clk_i; peripheral signals on clk_i
// Notes:   Routed outputs are combinational by design, not registered
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module pxf_fabric
    import pxf_pkg::*;
(
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Register port
    input  wire logic [pxf_pkg::ADDR_W-1:0]        reg_addr_i,
    input  wire logic [pxf_pkg::DATA_W-1:0]        reg_wdata_i,
    input  wire logic                              reg_wr_i,
    input  wire logic                              reg_rd_i,
    output logic      [pxf_pkg::DATA_W-1:0]        reg_rdata_o,
    // Sources
    input  wire logic [5:0]                        routing_pin_input_i,
    input  wire logic [2:0]                        comparator_result_i,
    input  wire logic [3:0]                        timer_b_channel_i,
    input  wire logic [3:0]                        pwm_trigger_a_i,
    input  wire logic [3:0]                        pwm_trigger_b_i,
    // Timer input path when the fabric does not own it
    input  wire logic [3:0]                        timer_b_alt_i,
    // ADC limit compare
    input  wire logic [pxf_pkg::NUM_SLOT-1:0]      adc_result_valid_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_result_slot_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_high_limit_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_low_limit_i,
    // Destinations
    output logic      [5:0]                        routing_pin_output_o,
    output logic      [1:0]                        adc_trigger_o,
    output logic                                   dac_sync_o,
    output logic      [2:0]                        comparator_window_o,
    output logic      [3:0]                        pwm_alt_control_a_o,
    output logic      [3:0]                        pwm_external_sync_o,
    output logic                                   pwm_external_clock_o,
    output logic      [3:0]                        pwm_fault_input_o,
    output logic                                   pwm_force_o,
    output logic      [3:0]                        timer_b_input_o,
    output logic      [3:0]                        pwm_alt_control_b_o
);
    logic [NUM_SRC-1:0]        fabric_source;
    logic [NUM_DEST-1:0]       fabric_dest;
    logic [NUM_DEST*SEL_W-1:0] sel_flat;
    logic [NUM_SLOT-1:0]       alt_b_level;

    // Control registers
    logic [1:0]                system_protection_control_r;
    logic [1:0]                system_protection_control_nxt;
    logic [3:0]                peripheral_select_reg3_r;
    logic [3:0]                peripheral_select_reg3_nxt;
    logic [DATA_W-1:0]         rdata_r;
    logic [DATA_W-1:0]         rdata_nxt;

    logic                      prot_active;
    logic                      prot_locked;
    logic                      addr_is_sel;

    pxf_sel_if sel_if ();

    // Source pool
    always_comb begin
        fabric_source                  = '0;
        fabric_source[SRC_ZERO]        = 1'b0;
        fabric_source[SRC_ONE]         = 1'b1;
        fabric_source[SRC_PIN_LO +: 6] = routing_pin_input_i;
        fabric_source[SRC_UNUSED]      = 1'b0;
        fabric_source[SRC_CMP_LO +: 3] = comparator_result_i;
        fabric_source[SRC_TMR_LO +: 4] = timer_b_channel_i;
        fabric_source[SRC_PWM_OR_LO +: 3] = pwm_trigger_a_i[2:0] | pwm_trigger_b_i[2:0];
        fabric_source[SRC_PWM012_OR]   = |(pwm_trigger_a_i[2:0] | pwm_trigger_b_i[2:0]);
        fabric_source[SRC_PWM3_A]      = pwm_trigger_a_i[3];
        fabric_source[SRC_PWM3_B]      = pwm_trigger_b_i[3];
    end

    // Output muxes; selects past the pool read as low
    genvar g;
    generate
        for (g = 0; g < NUM_DEST; g++) begin : g_mux
            logic [SEL_W-1:0] sel;
            assign sel = sel_flat[g*SEL_W +: SEL_W];
            // Kept unregistered so trigger and fault paths see no clock delay
            assign fabric_dest[g] = (int'(sel) < NUM_SRC) ? fabric_source[sel] : 1'b0;
        end
    endgenerate

    // Destination fan-out
    always_comb begin
        routing_pin_output_o = fabric_dest[DST_PIN_LO +: 6];
        adc_trigger_o        = fabric_dest[DST_ADC_LO +: 2];
        dac_sync_o           = fabric_dest[DST_DAC];
        comparator_window_o  = fabric_dest[DST_CMP_LO +: 3];
        pwm_alt_control_a_o  = fabric_dest[DST_ALTA_LO +: 4];
        pwm_external_sync_o  = fabric_dest[DST_SYNC_LO +: 4];
        pwm_external_clock_o = fabric_dest[DST_CLK];
        pwm_fault_input_o    = fabric_dest[DST_FAULT_LO +: 4];
        pwm_force_o          = fabric_dest[DST_FORCE];
        for (int k = 0; k < 4; k++) begin
            timer_b_input_o[k] = peripheral_select_reg3_r[k] ? fabric_dest[DST_TMR_LO + k] : timer_b_alt_i[k];
        end
    end

    // Select storage
    assign prot_active    = system_protection_control_r[PROT_EN_BIT];
    assign prot_locked    = system_protection_control_r[PROT_LOCK_BIT];
    assign addr_is_sel    = (reg_addr_i >= OFS_SEL_BASE) && (reg_addr_i <= OFS_SEL_LAST);
    assign sel_if.wr_en   = reg_wr_i && addr_is_sel && !prot_active;
    assign sel_if.wr_idx  = 5'(reg_addr_i - OFS_SEL_BASE);
    assign sel_if.wr_data = reg_wdata_i[SEL_W-1:0];
    assign sel_flat       = sel_if.sel_flat;

    pxf_sel_bank #(
        .N      (NUM_DEST)
    ) u_sel_bank (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .sel_if (sel_if)
    );

    // Protection and timer-select registers; lock freezes protection until reset
    always_comb begin
        system_protection_control_nxt = system_protection_control_r;
        peripheral_select_reg3_nxt    = peripheral_select_reg3_r;
        if (reg_wr_i && (reg_addr_i == OFS_PROT) && !prot_locked) begin
            system_protection_control_nxt = reg_wdata_i[1:0];
        end
        if (reg_wr_i && (reg_addr_i == OFS_GPS3)) begin
            peripheral_select_reg3_nxt = reg_wdata_i[GPS3_TMR_LSB +: 4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_protection_control_r <= PROT_RST;
            peripheral_select_reg3_r    <= GPS3_RST;
        end else begin
            system_protection_control_r <= system_protection_control_nxt;
            peripheral_select_reg3_r    <= peripheral_select_reg3_nxt;
        end
    end

    // Read path; data valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_i) begin
            if (addr_is_sel) begin
                rdata_nxt[SEL_W-1:0] = sel_flat[int'(reg_addr_i - OFS_SEL_BASE)*SEL_W +: SEL_W];
            end else if (reg_addr_i == OFS_PROT) begin
                rdata_nxt[1:0] = system_protection_control_r;
            end else if (reg_addr_i == OFS_GPS3) begin
                rdata_nxt[GPS3_TMR_LSB +: 4] = peripheral_select_reg3_r;
            end else if (reg_addr_i == OFS_STATUS) begin
                rdata_nxt[3:0] = pwm_alt_control_b_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // Fixed ADC limit path, outside the crossbar
    pxf_limit_hold #(
        .SLOTS    (NUM_SLOT),
        .RES_W    (ADC_W)
    ) u_limit_hold (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .valid_i  (adc_result_valid_i),
        .result_i (adc_result_slot_i),
        .high_i   (adc_high_limit_i),
        .low_i    (adc_low_limit_i),
        .level_o  (alt_b_level)
    );

    assign pwm_alt_control_b_o = {1'b0, alt_b_level};
endmodule

// file: rtl/pxf_limit_hold.sv
// Purpose: Limit-compare latch driving the second PWM alternate controls
// Assumes: Results, limits and strobes come from logic on clk_i
// Notes:   Level only moves on a valid strobe, so it holds between limits
`timescale 1ns/10ps
module pxf_limit_hold
    import pxf_pkg::*;
#(
    parameter int SLOTS = NUM_SLOT,
    parameter int RES_W = ADC_W
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [SLOTS-1:0]       valid_i,
    input  wire logic [SLOTS*RES_W-1:0] result_i,
    input  wire logic [SLOTS*RES_W-1:0] high_i,
    input  wire logic [SLOTS*RES_W-1:0] low_i,
    output logic      [SLOTS-1:0]       level_o
);
    logic [SLOTS-1:0] level_r;
    logic [SLOTS-1:0] level_nxt;

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            always_comb begin
                level_nxt[g] = level_r[g];
                if (valid_i[g]) begin
                    if (result_i[g*RES_W +: RES_W] > high_i[g*RES_W +: RES_W]) begin
                        level_nxt[g] = 1'b0;
                    end else if (result_i[g*RES_W +: RES_W] < low_i[g*RES_W +: RES_W]) begin
                        level_nxt[g] = 1'b1;
                    end
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    level_r[g] <= LEVEL_RST;
                end else begin
                    level_r[g] <= level_nxt[g];
                end
            end
        end
    endgenerate

    assign level_o = level_r;
endmodule

// file: rtl/pxf_pkg.sv
// Purpose: Shared constants for the peripheral crossbar fabric
// Assumes: Word-indexed plain register port, 16-bit data
// Notes:   Register offsets are register indices on the plain port
package pxf_pkg;
    localparam int          NUM_DEST       = 30;
    localparam int          NUM_SRC        = 22;
    localparam int          SEL_W          = 5;
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 16;
    localparam int          ADC_W          = 12;
    localparam int          NUM_SLOT       = 3;

    // Register map
    localparam logic [5:0]  OFS_SEL_BASE   = 6'h00;
    localparam logic [5:0]  OFS_SEL_LAST   = 6'h1D;
    localparam logic [5:0]  OFS_PROT       = 6'h20;
    localparam logic [5:0]  OFS_GPS3       = 6'h21;
    localparam logic [5:0]  OFS_STATUS     = 6'h22;

    // Field positions
    localparam int          PROT_EN_BIT    = 0;
    localparam int          PROT_LOCK_BIT  = 1;
    localparam int          GPS3_TMR_LSB   = 12;

    // Reset values
    localparam logic [4:0]  SEL_RST        = 5'h00;
    localparam logic [1:0]  PROT_RST       = 2'h0;
    localparam logic [3:0]  GPS3_RST       = 4'h0;
    localparam logic        LEVEL_RST      = 1'b0;

    // Source indices
    localparam int          SRC_ZERO       = 0;
    localparam int          SRC_ONE        = 1;
    localparam int          SRC_PIN_LO     = 2;
    localparam int          SRC_UNUSED     = 8;
    localparam int          SRC_CMP_LO     = 9;
    localparam int          SRC_TMR_LO     = 12;
    localparam int          SRC_PWM_OR_LO  = 16;
    localparam int          SRC_PWM012_OR  = 19;
    localparam int          SRC_PWM3_A     = 20;
    localparam int          SRC_PWM3_B     = 21;

    // Destination indices
    localparam int          DST_PIN_LO     = 0;
    localparam int          DST_ADC_LO     = 6;
    localparam int          DST_DAC        = 8;
    localparam int          DST_CMP_LO     = 9;
    localparam int          DST_ALTA_LO    = 12;
    localparam int          DST_SYNC_LO    = 16;
    localparam int          DST_CLK        = 20;
    localparam int          DST_FAULT_LO   = 21;
    localparam int          DST_FORCE      = 25;
    localparam int          DST_TMR_LO     = 26;
endpackage

// file: rtl/pxf_sel_bank.sv
// Purpose: Storage for the crossbar select fields
// Assumes: Writes already filtered by protection
// Notes:   All fields visible at once; the fabric needs them in parallel
`timescale 1ns/10ps
module pxf_sel_bank
    import pxf_pkg::*;
#(
    parameter int N = NUM_DEST
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    pxf_sel_if.store   sel_if
);
    logic [N*SEL_W-1:0] sel_r;
    logic [N*SEL_W-1:0] sel_nxt;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_fld
            always_comb begin
                sel_nxt[g*SEL_W +: SEL_W] = sel_r[g*SEL_W +: SEL_W];
                if (sel_if.wr_en && (sel_if.wr_idx == 5'(g))) begin
                    sel_nxt[g*SEL_W +: SEL_W] = sel_if.wr_data;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sel_r[g*SEL_W +: SEL_W] <= SEL_RST;
                end else begin
                    sel_r[g*SEL_W +: SEL_W] <= sel_nxt[g*SEL_W +: SEL_W];
                end
            end
        end
    endgenerate

    assign sel_if.sel_flat = sel_r;
endmodule

// file: rtl/pxf_sel_if.sv
// Purpose: Select-store write port and parallel select bus
// Assumes: One writer, one store
// Notes:   Select bus is the flop outputs, read in parallel
`timescale 1ns/10ps
interface pxf_sel_if;
    import pxf_pkg::*;
    logic                        wr_en;
    logic [4:0]                  wr_idx;
    logic [SEL_W-1:0]            wr_data;
    logic [NUM_DEST*SEL_W-1:0]   sel_flat;
    modport store (input wr_en, input wr_idx, input wr_data, output sel_flat);
    modport ctrl  (output wr_en, output wr_idx, output wr_data, input sel_flat);
endinterface

// file: verification/pxf_fabric_sva.sv
// Purpose: Port-level checks for the peripheral crossbar fabric
// Assumes: Synchronous active-high reset on clk_i
// Notes:   Select contents are not mirrored here; the bench judges routing
`timescale 1ns/10ps
module pxf_fabric_sva
    import pxf_pkg::*;
(
    input  wire logic [5:0]                              routing_pin_output_o,
    input  wire logic                                    clk_i,
    input  wire logic                                    rst_i,
    input  wire logic [pxf_pkg::ADDR_W-1:0]              reg_addr_i,
    input  wire logic [pxf_pkg::DATA_W-1:0]              reg_wdata_i,
    input  wire logic                                    reg_wr_i,
    input  wire logic [3:0]                              timer_b_alt_i,
    input  wire logic [pxf_pkg::NUM_SLOT-1:0]            adc_result_valid_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_result_slot_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_high_limit_i,
    input  wire logic [pxf_pkg::NUM_SLOT*pxf_pkg::ADC_W-1:0] adc_low_limit_i,
    input  wire logic [1:0]                              adc_trigger_o,
    input  wire logic [3:0]                              timer_b_input_o,
    input  wire logic [3:0]                              pwm_alt_control_b_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_tie_low;
        pwm_alt_control_b_o[3] == 1'b0;
    endproperty
    a_tie_low: assert property (p_tie_low)
        else $error("alt b3 not low");
    property p_above;
        adc_result_valid_i[0] && (adc_result_slot_i[11:0] > adc_high_limit_i[11:0]) |=> !pwm_alt_control_b_o[0];
    endproperty
    a_above: assert property (p_above)
        else $error("slot0 above high not low");
    property p_below;
        adc_result_valid_i[1] && !(adc_result_slot_i[23:12] > adc_high_limit_i[23:12])
            && (adc_result_slot_i[23:12] < adc_low_limit_i[23:12]) |=> pwm_alt_control_b_o[1];
    endproperty
    a_below: assert property (p_below)
        else $error("slot1 below low not high");
    property p_between;
        adc_result_valid_i[0] && !(adc_result_slot_i[11:0] > adc_high_limit_i[11:0])
            && !(adc_result_slot_i[11:0] < adc_low_limit_i[11:0]) |=> $stable(pwm_alt_control_b_o[0]);
    endproperty
    a_between: assert property (p_between)
        else $error("slot0 inside limits moved");
    property p_idle;
        !adc_result_valid_i[2] |=> $stable(pwm_alt_control_b_o[2]);
    endproperty
    a_idle: assert property (p_idle)
        else $error("slot2 moved without strobe");
    property p_slot2;
        adc_result_valid_i[2] && (adc_result_slot_i[35:24] > adc_high_limit_i[35:24]) |=> !pwm_alt_control_b_o[2];
    endproperty
    a_slot2: assert property (p_slot2)
        else $error("slot2 not mapped to alt b2");
    property p_timer_off;
        reg_wr_i && (reg_addr_i == OFS_GPS3) && (reg_wdata_i[15:12] == 4'h0) |=> timer_b_input_o == timer_b_alt_i;
    endproperty
    a_timer_off: assert property (p_timer_off)
        else $error("timer input not on alternate path");
    property p_reset_zero;
        $fell(rst_i) |-> (routing_pin_output_o == 6'h00) && (adc_trigger_o == 2'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not low after reset");
    c_above: cover property (adc_result_valid_i[0] && (adc_result_slot_i[11:0] > adc_high_limit_i[11:0]));
    c_below: cover property (adc_result_valid_i[1] && (adc_result_slot_i[23:12] < adc_low_limit_i[23:12]));
    c_prot: cover property (reg_wr_i && (reg_addr_i == OFS_PROT));
endmodule

bind pxf_fabric pxf_fabric_sva i_sva (.routing_pin_output_o(routing_pin_output_o), .clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .timer_b_alt_i(timer_b_alt_i),
    .adc_result_valid_i(adc_result_valid_i), .adc_result_slot_i(adc_result_slot_i),
    .adc_high_limit_i(adc_high_limit_i), .adc_low_limit_i(adc_low_limit_i), .adc_trigger_o(adc_trigger_o),
    .timer_b_input_o(timer_b_input_o), .pwm_alt_control_b_o(pwm_alt_control_b_o));

// file: verification/pxf_periph_model.sv
// Purpose: Behavioural peripheral side: pins, comparators, timers, PWM triggers, ADC
// Assumes: Driven from the bench on clk_i
// Notes:   Result bus shows junk outside its strobe, as a real ADC may
`timescale 1ns/10ps
module pxf_periph_model (
    input  wire logic        clk_i,
    input  wire logic [24:0] pat_i,
    input  wire logic        go_i,
    input  wire logic [1:0]  slot_i,
    input  wire logic [35:0] smp_i,
    output logic      [24:0] raw_o,
    output logic      [2:0]  valid_o,
    output logic      [35:0] res_o,
    output logic      [35:0] hi_o,
    output logic      [35:0] lo_o
);
    initial begin
        raw_o = '0;
        valid_o = '0;
        res_o = '0;
        hi_o = '0;
        lo_o = '0;
    end
    always @(posedge clk_i) begin
        raw_o <= pat_i;
        valid_o <= '0;
        res_o <= ~res_o;
        if (go_i) begin
            valid_o[slot_i] <= 1'b1;
            res_o[slot_i*12+:12] <= smp_i[11:0];
            hi_o[slot_i*12+:12] <= smp_i[23:12];
            lo_o[slot_i*12+:12] <= smp_i[35:24];
        end
    end
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the peripheral crossbar fabric
// Assumes: Partner model supplies every peripheral signal
// Notes:   Routing is checked mid-cycle, so a register stage would show
`timescale 1ns/10ps
module tb_top;
    import pxf_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [5:0]  addr = '0;
    logic [15:0] wdata = '0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [24:0] pat = 25'h1FF_FFFF;
    logic        go = 1'b0;
    logic [1:0]  slot = '0;
    logic [35:0] smp = '0;
    logic [15:0] rdata;
    logic [24:0] raw;
    logic [2:0]  vld;
    logic [35:0] res;
    logic [35:0] hi;
    logic [35:0] lo;
    logic [29:0] dv;
    logic [3:0]  ab;
    int          errors = 0;
    int          tests_run = 0;

    initial forever #25 clk_i = ~clk_i;

    pxf_periph_model i_peer (.clk_i(clk_i), .pat_i(pat), .go_i(go), .slot_i(slot), .smp_i(smp), .raw_o(raw),
        .valid_o(vld), .res_o(res), .hi_o(hi), .lo_o(lo));
    pxf_fabric i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .routing_pin_input_i(raw[5:0]), .comparator_result_i(raw[8:6]),
        .timer_b_channel_i(raw[12:9]), .pwm_trigger_a_i(raw[16:13]), .pwm_trigger_b_i(raw[20:17]),
        .timer_b_alt_i(raw[24:21]), .adc_result_valid_i(vld), .adc_result_slot_i(res), .adc_high_limit_i(hi),
        .adc_low_limit_i(lo), .routing_pin_output_o(dv[5:0]), .adc_trigger_o(dv[7:6]), .dac_sync_o(dv[8]),
        .comparator_window_o(dv[11:9]), .pwm_alt_control_a_o(dv[15:12]), .pwm_external_sync_o(dv[19:16]),
        .pwm_external_clock_o(dv[20]), .pwm_fault_input_o(dv[24:21]), .pwm_force_o(dv[25]),
        .timer_b_input_o(dv[29:26]), .pwm_alt_control_b_o(ab));

    task automatic close_out();
        $display("Counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        @(negedge clk_i);
        chk(30'(rdata), 30'(exp));
        @(negedge clk_i);
        chk(30'(rdata), 30'h0000_0000);
    endtask

    // Source pool as the fabric should see it, built from the peripheral side
    function automatic logic [21:0] src_vec();
        logic [2:0] o;
        o = raw[15:13] | raw[19:17];
        return {raw[20], raw[16], |o, o, raw[12:9], raw[8:6], 1'b0, raw[5:0], 2'b10};
    endfunction

    task automatic t_reset();
        @(negedge clk_i);
        chk(dv, 30'h3C00_0000);
        chk(30'(ab), 30'h0000_0000);
        rd_chk(OFS_SEL_BASE, 16'h0000);
        rd_chk(OFS_PROT, 16'h0000);
    endtask

    task automatic t_route();
        logic [21:0] s;
        logic [29:0] e;
        wr(OFS_GPS3, 16'hF000);
        for (int k = 0; k < 22; k++) begin
            for (int d = 0; d < 30; d++)
                wr(6'(d), 16'((d + k) % 22));
            for (int p = 0; p < 3; p++) begin
                @(posedge clk_i);
                pat <= 25'(32'h9E37_79B9 * (3 * k + p + 1));
                @(posedge clk_i);
                @(negedge clk_i);
                s = src_vec();
                for (int d = 0; d < 30; d++)
                    e[d] = s[(d + k) % 22];
                chk(dv, e);
            end
        end
        // Selects past the pool read as constant low
        wr(OFS_SEL_BASE, 16'h001F);
        @(negedge clk_i);
        chk(30'(dv[0]), 30'h0000_0000);
    endtask

    task automatic t_timer();
        for (int d = DST_TMR_LO; d < NUM_DEST; d++)
            wr(6'(d), 16'(SRC_ONE));
        wr(OFS_GPS3, 16'h5000);
        @(posedge clk_i);
        pat <= 25'h140_0000;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(30'(dv[29:26]), 30'h0000_000F);
        rd_chk(OFS_GPS3, 16'h5000);
        @(posedge clk_i);
        pat <= 25'h000_0000;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(30'(dv[29:26]), 30'h0000_0005);
        wr(OFS_GPS3, 16'h0000);
        @(negedge clk_i);
        chk(30'(dv[29:26]), 30'h0000_0000);
    endtask

    task automatic t_prot();
        wr(6'(DST_ADC_LO), 16'(SRC_ONE));
        wr(OFS_PROT, 16'h0001);
        wr(6'(DST_ADC_LO), 16'(SRC_ZERO));
        @(negedge clk_i);
        chk(30'(dv[6]), 30'h0000_0001);
        rd_chk(6'(DST_ADC_LO), 16'h0001);
        rd_chk(6'h3F, 16'h0000);
        wr(OFS_PROT, 16'h0000);
        wr(6'(DST_ADC_LO), 16'(SRC_ZERO));
        @(negedge clk_i);
        chk(30'(dv[6]), 30'h0000_0000);
    endtask

    task automatic t_limit();
        logic [11:0] rv [6] = '{12'h900, 12'h050, 12'h400, 12'h801, 12'h800, 12'h0FF};
        logic [5:0]  lv = 6'h26;
        for (int n = 0; n < 3; n++) begin
            for (int i = 0; i < 6; i++) begin
                @(posedge clk_i);
                go <= 1'b1;
                slot <= 2'(n);
                smp <= {12'h100, 12'h800, rv[i]};
                @(posedge clk_i);
                go <= 1'b0;
                @(posedge clk_i);
                @(negedge clk_i);
                chk(30'(ab[n]), 30'(lv[i]));
            end
        end
        chk(30'(ab[3]), 30'h0000_0000);
        rd_chk(OFS_STATUS, 16'h0007);
    endtask

    task automatic t_lock();
        wr(OFS_PROT, 16'h0003);
        wr(OFS_PROT, 16'h0000);
        wr(6'(DST_DAC), 16'(SRC_ONE));
        @(negedge clk_i);
        chk(30'(dv[8]), 30'h0000_0000);
        rd_chk(OFS_PROT, 16'h0003);
        // Only a reset lifts the lock
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(dv, 30'h0000_0000);
        chk(30'(ab), 30'h0000_0000);
        rd_chk(OFS_PROT, 16'h0000);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        $display("test reset done");
        t_route();
        $display("test route done");
        t_timer();
        $display("test timer done");
        t_prot();
        $display("test protect done");
        t_limit();
        $display("test limit done");
        t_lock();
        $display("test lock done");
        close_out();
    end

    // Whole run is near 1600 cycles; the margin only catches a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        close_out();
    end
endmodule
